// ==== src/readback_mirror_mem.sv ====
// Register mirror memory with registered read data
`timescale 1ns/100ps
`default_nettype none

module readback_mirror_mem #(
  parameter int WIDTH = 16,
  parameter int ADDR_W = 5
) (
  // Clock
  input wire logic i_clk,
  // Write port
  input wire logic i_we,
  input wire logic [ADDR_W-1:0] i_waddr,
  input wire logic [WIDTH-1:0] i_wdata,
  // Read port
  input wire logic [ADDR_W-1:0] i_raddr,
  output logic [WIDTH-1:0] o_rdata
);

  logic [WIDTH-1:0] mem [2**ADDR_W];

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    o_rdata <= mem[i_raddr];
  end

endmodule

`default_nettype wire

// ==== src/readback_pkg.sv ====
// Shared constants and carrier types for the serial readback and status block
package readback_pkg;

  // Frame geometry
  localparam int FRAME_BITS = 24;
  localparam int PEC_FRAME_BITS = 32;
  localparam int CRC_W = 8;
  localparam int DATA_W = 16;
  localparam int SEL_W = 5;
  localparam int COUNT_W = 6;
  localparam logic [COUNT_W-1:0] COUNT_PLAIN = 6'h18;
  localparam logic [COUNT_W-1:0] COUNT_PEC = 6'h20;
  localparam logic [COUNT_W-1:0] COUNT_MAX = 6'h3F;

  // Packet check: x^8 + x^2 + x + 1
  localparam logic [CRC_W-1:0] CRC_POLY = 8'h07;
  localparam logic [CRC_W-1:0] CRC_INIT = 8'h00;

  // Special command words
  localparam logic [FRAME_BITS-1:0] NOP_WORD = 24'h3CE000;

  // Register select codes
  localparam logic [SEL_W-1:0] SEL_SLEW_FIRST = 5'h14;
  localparam logic [SEL_W-1:0] SEL_SLEW_LAST = 5'h17;
  localparam logic [SEL_W-1:0] SEL_STATUS = 5'h18;
  localparam logic [SEL_W-1:0] SEL_LAST = 5'h1A;
  localparam logic [1:0] SEL_CHAN_MASK = 2'h3;

  // Upper readback byte, undefined on the wire, driven as zero
  localparam logic [7:0] READBACK_PAD = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;

  // Frame tracking states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACTIVE = 2'b01,
    ST_FINISH = 2'b10
  } frame_state_t;

  // Read request word layout
  typedef struct packed {
    logic rw;
    logic device_addr_hi;
    logic device_addr_lo;
    logic [SEL_W-1:0] reg_sel;
    logic [15:0] ignored;
  } read_req_t;

  // Slew rate control register layout
  typedef struct packed {
    logic [2:0] zero;
    logic slew_enable;
    logic [4:0] ignored;
    logic [3:0] slew_update_rate;
    logic [2:0] slew_step_size;
  } slew_ctrl_t;

  // Fault status register layout, channel index 3 is D and 0 is A
  typedef struct packed {
    logic [3:0] boost_limit;
    logic user_toggle;
    logic packet_check_error;
    logic ramp_active;
    logic over_temp;
    logic [3:0] undefined;
    logic [3:0] out_fault;
  } fault_status_t;

  // Packet check over a 24-bit word, MSB first
  function automatic logic [CRC_W-1:0] crc8(input logic [FRAME_BITS-1:0] d);
    logic [CRC_W-1:0] c;
    logic fb;
    c = CRC_INIT;
    fb = 1'b0;
    for (int i = FRAME_BITS - 1; i >= 0; i--) begin
      fb = c[CRC_W-1] ^ d[i];
      c = {c[CRC_W-2:0], 1'b0};
      if (fb) begin
        c = c ^ CRC_POLY;
      end
    end
    return c;
  endfunction

endpackage

// ==== src/serial_readback_status.sv ====
// Serial port readback path with fault status register
`timescale 1ns/100ps
`default_nettype none

module serial_readback_status #(
  parameter int CHANNELS = 4
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Serial port
  input wire logic i_sclk,
  input wire logic i_sync_n,
  input wire logic i_sdin,
  output logic o_serial_out,
  output logic o_serial_oe,
  // Device address pins
  input wire logic i_device_addr_hi,
  input wire logic i_device_addr_lo,
  // Main control bits
  input wire logic i_status_on_write,
  input wire logic i_packet_check,
  // Status sources
  input wire logic [CHANNELS-1:0] i_boost_limit,
  input wire logic [CHANNELS-1:0] i_out_fault,
  input wire logic [CHANNELS-1:0] i_chan_stepping,
  input wire logic i_over_temp,
  input wire logic i_user_toggle,
  // Register mirror updates from the core
  input wire logic i_mirror_we,
  input wire logic [readback_pkg::SEL_W-1:0] i_mirror_sel,
  input wire logic [readback_pkg::DATA_W-1:0] i_mirror_data,
  // Decoded write words to the core
  output logic o_wr_valid,
  output logic [readback_pkg::FRAME_BITS-1:0] o_wr_word,
  // Fault pin, open drain
  output logic o_fault_o,
  output logic o_fault_oe,
  // Status view
  output readback_pkg::fault_status_t o_status
);

  readback_pkg::frame_state_t state_r;
  readback_pkg::frame_state_t state_nxt;
  logic sclk_d_r;
  logic sync_n_d_r;
  logic sclk_fall;
  logic sclk_rise;
  logic frame_start;
  logic frame_end;
  logic [readback_pkg::PEC_FRAME_BITS-1:0] rx_shift_r;
  logic [readback_pkg::COUNT_W-1:0] rx_count_r;
  logic [readback_pkg::PEC_FRAME_BITS-1:0] tx_shift_r;
  logic serial_out_r;
  logic serial_oe_r;
  logic pend_valid_r;
  logic [readback_pkg::SEL_W-1:0] pend_sel_r;
  logic sent_status_r;
  logic pec_error_r;
  logic [CHANNELS-1:0] slew_en_r;
  logic wr_valid_r;
  logic [readback_pkg::FRAME_BITS-1:0] wr_word_r;
  logic fault_oe_r;
  readback_pkg::fault_status_t status_r;
  readback_pkg::fault_status_t status_now;
  readback_pkg::slew_ctrl_t slew_in;
  readback_pkg::read_req_t req;
  logic [readback_pkg::FRAME_BITS-1:0] rx_word;
  logic [readback_pkg::CRC_W-1:0] rx_crc;
  logic plain_frame;
  logic pec_frame;
  logic pec_bad;
  logic word_ok;
  logic is_read;
  logic addr_match;
  logic is_nop;
  logic [readback_pkg::DATA_W-1:0] mem_rdata;
  logic [readback_pkg::DATA_W-1:0] mirror_wdata;
  logic mirror_slew;
  logic mirror_we_ok;
  logic [readback_pkg::DATA_W-1:0] tx_data;
  logic tx_status;
  logic tx_drive;
  logic [readback_pkg::FRAME_BITS-1:0] tx_word;
  logic [readback_pkg::CRC_W-1:0] tx_crc;

  // Pin sampling for edge detection; serial clock idles high, so no false edge after reset
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      sclk_d_r <= 1'b1;
      sync_n_d_r <= 1'b1;
    end else begin
      sclk_d_r <= i_sclk;
      sync_n_d_r <= i_sync_n;
    end
  end

  assign sclk_fall = sclk_d_r & ~i_sclk;
  assign sclk_rise = ~sclk_d_r & i_sclk;
  assign frame_start = sync_n_d_r & ~i_sync_n;
  assign frame_end = ~sync_n_d_r & i_sync_n;

  // Frame state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      readback_pkg::ST_IDLE: begin
        if (frame_start) begin
          state_nxt = readback_pkg::ST_ACTIVE;
        end
      end
      readback_pkg::ST_ACTIVE: begin
        if (frame_end) begin
          state_nxt = readback_pkg::ST_FINISH;
        end
      end
      readback_pkg::ST_FINISH: begin
        state_nxt = readback_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = readback_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_r <= readback_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Input shift register, sampled on falling serial clock
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      rx_shift_r <= '0;
      rx_count_r <= '0;
    end else if (frame_start) begin
      rx_count_r <= '0;
    end else if (state_r == readback_pkg::ST_ACTIVE && sclk_fall) begin
      rx_shift_r <= {rx_shift_r[readback_pkg::PEC_FRAME_BITS-2:0], i_sdin};
      if (rx_count_r != readback_pkg::COUNT_MAX) begin
        rx_count_r <= rx_count_r + 6'h01;
      end
    end
  end

  // Frame decode
  assign plain_frame = (rx_count_r == readback_pkg::COUNT_PLAIN);
  assign pec_frame = (rx_count_r == readback_pkg::COUNT_PEC);
  assign rx_word = pec_frame ? rx_shift_r[readback_pkg::PEC_FRAME_BITS-1:readback_pkg::CRC_W]
                             : rx_shift_r[readback_pkg::FRAME_BITS-1:0];
  assign rx_crc = rx_shift_r[readback_pkg::CRC_W-1:0];
  assign pec_bad = pec_frame && (readback_pkg::crc8(rx_word) != rx_crc);
  assign word_ok = plain_frame || (pec_frame && !pec_bad);
  assign req = readback_pkg::read_req_t'(rx_word);
  assign is_read = req.rw;
  assign addr_match = (req.device_addr_hi == i_device_addr_hi) &&
                      (req.device_addr_lo == i_device_addr_lo);
  assign is_nop = (rx_word == readback_pkg::NOP_WORD);

  // Pending readback captured at the end of a read request
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      pend_valid_r <= 1'b0;
      pend_sel_r <= '0;
    end else if (state_r == readback_pkg::ST_FINISH && word_ok && is_read && addr_match) begin
      pend_valid_r <= 1'b1;
      pend_sel_r <= i_status_on_write ? readback_pkg::SEL_STATUS : req.reg_sel;
    end else if (frame_start) begin
      pend_valid_r <= 1'b0;
    end
  end

  // Write words other than reads and NOPs go to the core
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      wr_valid_r <= 1'b0;
      wr_word_r <= '0;
    end else begin
      wr_valid_r <= 1'b0;
      if (state_r == readback_pkg::ST_FINISH && word_ok && !is_read && !is_nop) begin
        wr_valid_r <= 1'b1;
        wr_word_r <= rx_word;
      end
    end
  end

  // Mirror of readable registers; status and unassigned codes are not stored
  assign mirror_slew = (i_mirror_sel >= readback_pkg::SEL_SLEW_FIRST) &&
                       (i_mirror_sel <= readback_pkg::SEL_SLEW_LAST);
  assign slew_in = readback_pkg::slew_ctrl_t'(i_mirror_data);
  assign mirror_we_ok = i_mirror_we && (i_mirror_sel != readback_pkg::SEL_STATUS) &&
                        (i_mirror_sel <= readback_pkg::SEL_LAST);

  always_comb begin
    mirror_wdata = i_mirror_data;
    if (mirror_slew) begin
      mirror_wdata = {3'h0, slew_in.slew_enable, 5'h00,
                      slew_in.slew_update_rate, slew_in.slew_step_size};
    end
  end

  readback_mirror_mem #(
    .WIDTH(readback_pkg::DATA_W),
    .ADDR_W(readback_pkg::SEL_W)
  ) u_mirror (
    .i_clk(i_clk),
    .i_we(mirror_we_ok),
    .i_waddr(i_mirror_sel),
    .i_wdata(mirror_wdata),
    .i_raddr(pend_sel_r),
    .o_rdata(mem_rdata)
  );

  // Per-channel slew enables kept for the ramp flag
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      slew_en_r <= '0;
    end else if (i_mirror_we && mirror_slew) begin
      slew_en_r[i_mirror_sel[1:0] & readback_pkg::SEL_CHAN_MASK] <= slew_in.slew_enable;
    end
  end

  // Live status assembly
  always_comb begin
    status_now = '0;
    status_now.boost_limit = i_boost_limit;
    status_now.user_toggle = i_user_toggle;
    status_now.packet_check_error = pec_error_r;
    status_now.ramp_active = |(i_chan_stepping & slew_en_r);
    status_now.over_temp = i_over_temp;
    status_now.undefined = '0;
    status_now.out_fault = i_out_fault | i_boost_limit;
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      status_r <= '0;
    end else begin
      status_r <= status_now;
    end
  end

  // Packet error flag: a new error wins over the clear by a status read
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      pec_error_r <= 1'b0;
    end else if (state_r == readback_pkg::ST_FINISH && pec_bad) begin
      pec_error_r <= 1'b1;
    end else if (state_r == readback_pkg::ST_FINISH && sent_status_r &&
                 rx_count_r >= readback_pkg::COUNT_PLAIN) begin
      pec_error_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      fault_oe_r <= 1'b0;
      o_fault_o <= 1'b0;
    end else begin
      fault_oe_r <= status_now.packet_check_error | status_now.over_temp |
                    (|status_now.out_fault);
      o_fault_o <= 1'b0;
    end
  end

  // Readback data chosen at frame start
  assign tx_status = (pend_valid_r && pend_sel_r == readback_pkg::SEL_STATUS) ||
                     (!pend_valid_r && i_status_on_write);
  assign tx_drive = pend_valid_r || i_status_on_write;

  always_comb begin
    if (tx_status) begin
      tx_data = status_now;
    end else if (pend_valid_r && pend_sel_r <= readback_pkg::SEL_LAST) begin
      tx_data = mem_rdata;
    end else begin
      tx_data = readback_pkg::DATA_ZERO;
    end
  end

  assign tx_word = {readback_pkg::READBACK_PAD, tx_data};
  // Computed from a stable word captured before any clock of the next frame
  assign tx_crc = i_packet_check ? readback_pkg::crc8(tx_word) : readback_pkg::CRC_INIT;

  // Output shifter: MSB ready at frame start, advances on rising serial clock
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      tx_shift_r <= '0;
      serial_out_r <= 1'b0;
      serial_oe_r <= 1'b0;
      sent_status_r <= 1'b0;
    end else if (frame_start) begin
      tx_shift_r <= {tx_word, tx_crc};
      serial_out_r <= tx_word[readback_pkg::FRAME_BITS-1];
      serial_oe_r <= tx_drive;
      sent_status_r <= tx_status;
    end else if (state_r == readback_pkg::ST_ACTIVE && sclk_rise && rx_count_r != '0) begin
      tx_shift_r <= {tx_shift_r[readback_pkg::PEC_FRAME_BITS-2:0], 1'b0};
      serial_out_r <= tx_shift_r[readback_pkg::PEC_FRAME_BITS-2];
    end else if (frame_end) begin
      serial_oe_r <= 1'b0;
    end
  end

  assign o_serial_out = serial_out_r;
  assign o_serial_oe = serial_oe_r;
  assign o_wr_valid = wr_valid_r;
  assign o_wr_word = wr_word_r;
  assign o_fault_oe = fault_oe_r;
  assign o_status = status_r;

endmodule

`default_nettype wire

// ==== tb/readback_host.sv ====
// Host model driving the serial port and collecting readback bits
`timescale 1ns/100ps
`default_nettype none
module readback_host (
  // Clock
  input wire logic i_clk,
  // Serial port
  output logic o_sclk,
  output logic o_sync_n,
  output logic o_sdin,
  input wire logic i_serial_out
);
  localparam int PHASE = 4;
  initial begin
    o_sclk = 1'b1;
    o_sync_n = 1'b1;
    o_sdin = 1'b0;
  end
  // One frame of n bits, MSB first; clock idles high outside it
  task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] rx);
    rx = 32'h0;
    o_sync_n <= 1'b0;
    repeat (PHASE) @(posedge i_clk);
    for (int i = n - 1; i >= 0; i--) begin
      o_sdin <= w[i];
      repeat (PHASE) @(posedge i_clk);
      rx = {rx[30:0], i_serial_out};
      o_sclk <= 1'b0;
      repeat (PHASE) @(posedge i_clk);
      o_sclk <= 1'b1;
    end
    repeat (PHASE) @(posedge i_clk);
    o_sync_n <= 1'b1;
    o_sdin <= ~o_sdin;
    repeat (6) @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

// ==== tb/serial_readback_status_bench.sv ====
// Self-checking bench for the serial readback and status block
`timescale 1ns/100ps
`default_nettype none
module serial_readback_status_bench;
  localparam logic [4:0] rb_sel [7] = '{5'h00, 5'h07, 5'h08, 5'h0F, 5'h14, 5'h1A, 5'h1B};
  localparam logic [15:0] rb_val [7] = '{16'h1111, 16'h2222, 16'h3333, 16'h4444, 16'hFFFF,
    16'h5555, 16'h6666};
  localparam logic [15:0] rb_exp [7] = '{16'h1111, 16'h2222, 16'h3333, 16'h4444, 16'h107F,
    16'h5555, 16'h0000};
  logic i_clk, i_reset, sclk, sync_n, sdin, serial_out, sdo_oe, sow, pec_on, otemp, utog;
  logic mwe, wr_valid, fault_o, fault_oe, oe_seen;
  logic [3:0] boost, ofault, stepping;
  logic [4:0] msel;
  logic [15:0] mdata;
  logic [23:0] wr_word;
  logic [31:0] rx;
  readback_pkg::fault_status_t status;
  int err_count, cmp_count, wr_cnt;
  serial_readback_status #(.CHANNELS(4)) u_dut (
    .i_clk(i_clk), .i_reset(i_reset), .i_sclk(sclk), .i_sync_n(sync_n), .i_sdin(sdin),
    .o_serial_out(serial_out), .o_serial_oe(sdo_oe), .i_device_addr_hi(1'b1),
    .i_device_addr_lo(1'b0), .i_status_on_write(sow), .i_packet_check(pec_on),
    .i_boost_limit(boost), .i_out_fault(ofault), .i_chan_stepping(stepping),
    .i_over_temp(otemp), .i_user_toggle(utog), .i_mirror_we(mwe), .i_mirror_sel(msel),
    .i_mirror_data(mdata), .o_wr_valid(wr_valid), .o_wr_word(wr_word), .o_fault_o(fault_o),
    .o_fault_oe(fault_oe), .o_status(status)
  );
  // Released output line shows the inverse of the last bit, so stale data cannot pass
  readback_host u_host (.i_clk(i_clk), .o_sclk(sclk), .o_sync_n(sync_n), .o_sdin(sdin),
    .i_serial_out(sdo_oe ? serial_out : ~serial_out));
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    if (wr_valid === 1'b1) wr_cnt++;
    if (sdo_oe === 1'b1) oe_seen = 1'b1;
  end
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  function automatic logic [7:0] ref_crc(input logic [23:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  function automatic logic [23:0] rd_req(input logic [1:0] a, input logic [4:0] s);
    return {1'b1, a, s, 16'h0000};
  endfunction
  task automatic set_in(input logic [3:0] b, input logic [3:0] f, input logic [3:0] s,
                        input logic t, input logic u);
    @(posedge i_clk);
    boost <= b;
    ofault <= f;
    stepping <= s;
    otemp <= t;
    utog <= u;
    repeat (3) @(posedge i_clk);
  endtask
  task automatic t_readback();
    int base;
    for (int i = 0; i < 7; i++) begin
      @(posedge i_clk);
      mwe <= 1'b1;
      msel <= rb_sel[i];
      mdata <= rb_val[i];
    end
    @(posedge i_clk);
    msel <= readback_pkg::SEL_STATUS;
    @(posedge i_clk);
    mwe <= 1'b0;
    base = wr_cnt;
    for (int i = 0; i < 8; i++) begin
      u_host.xfer({8'h00, (i < 7) ? rd_req(2'b10, rb_sel[i]) : readback_pkg::NOP_WORD}, 24, rx);
      if (i > 0) check("readback", {16'h0, rb_exp[i-1]}, {8'h0, rx[23:0]});
    end
    u_host.xfer({8'h00, rd_req(2'b01, 5'h08)}, 24, rx);
    oe_seen = 1'b0;
    u_host.xfer({8'h00, readback_pkg::NOP_WORD}, 24, rx);
    check("foreign read", 32'h0, {31'h0, oe_seen});
    check("write pulses", base, wr_cnt);
  endtask
  task automatic t_status();
    set_in(4'h2, 4'h8, 4'h1, 1'b1, 1'b1);
    check("status", 32'h2B0A, {16'h0, status});
    u_host.xfer({8'h00, rd_req(2'b10, readback_pkg::SEL_STATUS)}, 24, rx);
    u_host.xfer({8'h00, readback_pkg::NOP_WORD}, 24, rx);
    check("status read", 32'h2B0A, {8'h0, rx[23:0]});
    set_in(4'h0, 4'h0, 4'h2, 1'b0, 1'b0);
    check("status idle", 32'h0, {16'h0, status});
  endtask
  task automatic t_pec();
    logic [23:0] w;
    int base;
    base = wr_cnt;
    pec_on <= 1'b1;
    w = 24'h012345;
    u_host.xfer({w, ~ref_crc(w)}, 32, rx);
    check("bad frame", base, wr_cnt);
    check("pec flags", 32'h3, {30'h0, status.packet_check_error, fault_oe});
    w = rd_req(2'b10, readback_pkg::SEL_STATUS);
    u_host.xfer({w, ref_crc(w)}, 32, rx);
    u_host.xfer({readback_pkg::NOP_WORD, ref_crc(readback_pkg::NOP_WORD)}, 32, rx);
    check("pec read", {24'h000400, ref_crc(24'h000400)}, rx);
    repeat (3) @(posedge i_clk);
    check("pec cleared", 32'h0, {30'h0, status.packet_check_error, fault_oe});
    w = 24'h012345;
    u_host.xfer({w, ref_crc(w)}, 32, rx);
    check("good frame", base + 1, wr_cnt);
    check("write word", {8'h0, w}, {8'h0, wr_word});
    pec_on <= 1'b0;
  endtask
  task automatic t_sow();
    int base;
    base = wr_cnt;
    sow <= 1'b1;
    set_in(4'h0, 4'h1, 4'h0, 1'b0, 1'b1);
    u_host.xfer({8'h00, 24'h054321}, 24, rx);
    check("status on write", 32'h0801, {8'h0, rx[23:0]});
    check("write word", 32'h054321, {8'h0, wr_word});
    u_host.xfer({8'h00, rd_req(2'b10, 5'h08)}, 24, rx);
    u_host.xfer({8'h00, readback_pkg::NOP_WORD}, 24, rx);
    check("only status", 32'h0801, {8'h0, rx[23:0]});
    check("write pulses", base + 1, wr_cnt);
    sow <= 1'b0;
  endtask
  initial begin
    i_reset = 1'b1;
    {sow, pec_on, otemp, utog, mwe, oe_seen} = 6'h00;
    {boost, ofault, stepping} = 12'h000;
    msel = 5'h00;
    mdata = 16'h0000;
    err_count = 0;
    cmp_count = 0;
    wr_cnt = 0;
    repeat (5) @(posedge i_clk);
    check("reset", 32'h0, {13'h0, sdo_oe, wr_valid, fault_oe, status});
    i_reset <= 1'b0;
    repeat (3) @(posedge i_clk);
    t_readback();
    t_status();
    t_pec();
    t_sow();
    give_verdict();
  end
  initial begin
    #400000;
    err_count++;
    give_verdict();
  end
endmodule
`default_nettype wire

// ==== tb/serial_readback_status_properties.sv ====
// Port checker for the serial readback and status block
`timescale 1ns/100ps
`default_nettype none
module serial_readback_status_properties #(
  parameter int CHANNELS = 4
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Watched pins
  input wire logic i_sclk,
  input wire logic i_sync_n,
  input wire logic [CHANNELS-1:0] i_boost_limit,
  input wire logic [CHANNELS-1:0] i_out_fault,
  input wire logic i_user_toggle,
  input wire logic o_serial_out,
  input wire logic o_serial_oe,
  input wire logic o_wr_valid,
  input wire logic o_fault_o,
  input wire logic o_fault_oe,
  input wire readback_pkg::fault_status_t o_status
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  property p_boost; !$past(i_reset) |-> o_status.boost_limit == $past(i_boost_limit); endproperty
  a_boost: assert property (p_boost) else $error("boost flags wrong");
  property p_ofault;
    !$past(i_reset) |-> o_status.out_fault == $past(i_out_fault | i_boost_limit);
  endproperty
  a_ofault: assert property (p_ofault) else $error("output fault flags wrong");
  property p_toggle; !$past(i_reset) |-> o_status.user_toggle == $past(i_user_toggle); endproperty
  a_toggle: assert property (p_toggle) else $error("user toggle wrong");
  property p_wr_pulse; o_wr_valid |-> (i_sync_n && $past(i_sync_n)) ##1 !o_wr_valid; endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse wrong");
  property p_oe_frame; i_sync_n && $past(i_sync_n) && $past(i_sync_n, 2) |-> !o_serial_oe; endproperty
  a_oe_frame: assert property (p_oe_frame) else $error("output driven outside frame");
  property p_sdo_edge;
    o_serial_oe && $past(o_serial_oe) && $changed(o_serial_out) |->
      $past(i_sclk) || $past(i_sclk, 2);
  endproperty
  a_sdo_edge: assert property (p_sdo_edge) else $error("output moved off rising edge");
  property p_pec_set; $rose(o_status.packet_check_error) |-> i_sync_n && $past(i_sync_n); endproperty
  a_pec_set: assert property (p_pec_set) else $error("check error set inside frame");
  property p_fault_pin;
    (o_status.over_temp || o_status.packet_check_error) &&
      $past(o_status.over_temp || o_status.packet_check_error) |-> o_fault_oe && !o_fault_o;
  endproperty
  a_fault_pin: assert property (p_fault_pin) else $error("fault pin not pulled");
  c_frame: cover property ($fell(o_serial_oe));
  c_pec: cover property ($rose(o_status.packet_check_error));
  c_write: cover property (o_wr_valid);
endmodule
bind serial_readback_status serial_readback_status_properties #(.CHANNELS(CHANNELS)) u_props (
  .i_clk(i_clk), .i_reset(i_reset), .i_sclk(i_sclk), .i_sync_n(i_sync_n),
  .i_boost_limit(i_boost_limit), .i_out_fault(i_out_fault), .i_user_toggle(i_user_toggle),
  .o_serial_out(o_serial_out), .o_serial_oe(o_serial_oe), .o_wr_valid(o_wr_valid),
  .o_fault_o(o_fault_o), .o_fault_oe(o_fault_oe), .o_status(o_status)
);
`default_nettype wire
